// File: core/msd_pkg.sv
// Package of constants and types for the memory site decoder
package msd_pkg;
    // ==========================================
    // Address space
    localparam int ADDR_W = 20;
    localparam logic [19:0] ADDR_TOP = 20'hFFFFF;
    localparam int SITES_PER_BANK = 4;
    localparam int NUM_SITES = 12;
    localparam logic [19:0] RAM_BASE_LOW = 20'h00000;
    localparam logic [19:0] BASE_RST = 20'h00000;

    // ==========================================
    // Device density codes (per site)
    typedef enum logic [2:0] {
        MSD_DEN_2K,
        MSD_DEN_8K,
        MSD_DEN_16K,
        MSD_DEN_32K,
        MSD_DEN_64K
    } msd_density_t;

    // log2 of per-site bytes for each density
    localparam logic [4:0] LOG2_2K = 5'h0B;
    localparam logic [4:0] LOG2_8K = 5'h0D;
    localparam logic [4:0] LOG2_16K = 5'h0E;
    localparam logic [4:0] LOG2_32K = 5'h0F;
    localparam logic [4:0] LOG2_64K = 5'h10;
    // log2 of four sites on top of one site
    localparam logic [4:0] LOG2_BANK_EXTRA = 5'h02;

    // ==========================================
    // Bus request and select bundles
    typedef struct packed {
        logic valid;
        logic write;
        logic [19:0] addr;
    } msd_req_t;

    typedef struct packed {
        logic [3:0] prog_cs;
        logic [3:0] ram_cs;
        logic [3:0] addon_cs;
        logic hit;
    } msd_sel_t;

    localparam msd_sel_t SEL_NONE = '0;
endpackage

// File: core/msd_range.sv
// Range match and site index for one four-site bank
`timescale 1ns/1ps
module msd_range (
    input wire logic enable,
    input wire logic [19:0] addr,
    input wire logic [19:0] base,
    input wire logic [4:0] site_log2,
    output logic [3:0] cs
);
    logic [19:0] offset;
    logic [19:0] span;
    logic [1:0] site;

    always_comb begin
        offset = addr - base;
        span = 20'(20'h00001 << (site_log2 + msd_pkg::LOG2_BANK_EXTRA));
        site = 2'(offset >> site_log2);
        cs = 4'h0;
        if (enable && (addr >= base) && (offset < span)) begin
            cs[site] = 1'b1;
        end
    end
endmodule

// File: core/msd_decoder.sv
// Memory site decoder: places program, RAM and add-on banks and gates RAM
// =============================================================
`timescale 1ns/1ps
module msd_decoder (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire msd_pkg::msd_req_t req,
    input wire msd_pkg::msd_density_t prog_density,
    input wire msd_pkg::msd_density_t ram_density,
    input wire msd_pkg::msd_density_t addon_density,
    input wire logic ram_relocate,
    input wire logic addon_fitted,
    input wire logic mem_protect,
    output msd_pkg::msd_sel_t sel,
    output logic ram_blocked,
    output logic [19:0] prog_base,
    output logic [19:0] ram_base
);
    // =============================================================
    // Decode signals
    logic [4:0] prog_log2;
    logic [4:0] ram_log2;
    logic [4:0] addon_log2;
    logic [19:0] prog_span;
    logic [19:0] ram_span;

    logic [19:0] next_prog_base;
    logic [19:0] next_ram_base;
    logic [19:0] addon_base;

    logic ram_gate;
    logic addon_gate;
    logic [3:0] prog_cs;
    logic [3:0] ram_cs;
    logic [3:0] addon_cs;
    msd_pkg::msd_sel_t next_sel;

    logic [11:0] next_site_cs;
    logic [11:0] site_cs;
    logic next_hit;
    logic hit;
    logic next_ram_blocked;

    // =============================================================
    // Density decode
    function automatic logic [4:0] den_log2(input msd_pkg::msd_density_t d);
        unique case (d)
            msd_pkg::MSD_DEN_2K: den_log2 = msd_pkg::LOG2_2K;
            msd_pkg::MSD_DEN_8K: den_log2 = msd_pkg::LOG2_8K;
            msd_pkg::MSD_DEN_16K: den_log2 = msd_pkg::LOG2_16K;
            msd_pkg::MSD_DEN_32K: den_log2 = msd_pkg::LOG2_32K;
            msd_pkg::MSD_DEN_64K: den_log2 = msd_pkg::LOG2_64K;
            // Unused codes fall back to the smallest part
            default: den_log2 = msd_pkg::LOG2_2K;
        endcase
    endfunction

    // =============================================================
    // Site size per bank
    always_comb begin
        prog_log2 = den_log2(prog_density);
        ram_log2 = den_log2(ram_density);
        addon_log2 = den_log2(addon_density);
    end

    // Four sites per bank, so a bank spans four site sizes
    always_comb begin
        prog_span = 20'h00001 << (prog_log2 + msd_pkg::LOG2_BANK_EXTRA);
        ram_span = 20'h00001 << (ram_log2 + msd_pkg::LOG2_BANK_EXTRA);
    end

    // =============================================================
    // Program bank placement
    // Top-justified so the power-on fetch always lands in the top site
    always_comb begin
        next_prog_base = msd_pkg::ADDR_TOP - prog_span + 20'h00001;
    end

    // =============================================================
    // RAM bank placement
    always_comb begin
        if (ram_relocate) begin
            // Butts against the program bank so code can run on into it
            next_ram_base = next_prog_base - ram_span;
        end else begin
            next_ram_base = msd_pkg::RAM_BASE_LOW;
        end
    end

    // =============================================================
    // Add-on bank placement
    // Stepped by the RAM span; relocated, it lands on the program bank base, where the program bank wins
    always_comb begin
        addon_base = next_ram_base + ram_span;
    end

    // =============================================================
    // Bank gating
    // Add-on sites are on-board RAM too, so protect masks them as well
    always_comb begin
        ram_gate = req.valid && !mem_protect;
        addon_gate = req.valid && addon_fitted && !mem_protect;
    end

    // =============================================================
    // Per-bank range match, four sites each
    msd_range u_prog (
        .enable(req.valid),
        .addr(req.addr),
        .base(next_prog_base),
        .site_log2(prog_log2),
        .cs(prog_cs)
    );

    // Protect masks both reads and writes so battery contents survive
    msd_range u_ram (
        .enable(ram_gate),
        .addr(req.addr),
        .base(next_ram_base),
        .site_log2(ram_log2),
        .cs(ram_cs)
    );

    // 8K parts give four by 8K = 32K; 16K and up reach 64K and beyond
    msd_range u_addon (
        .enable(addon_gate),
        .addr(req.addr),
        .base(addon_base),
        .site_log2(addon_log2),
        .cs(addon_cs)
    );

    // =============================================================
    // Priority: program bank wins an overlap, then RAM, then add-on
    always_comb begin
        next_sel = msd_pkg::SEL_NONE;
        if (prog_cs != 4'h0) begin
            next_sel.prog_cs = prog_cs;
        end else if (ram_cs != 4'h0) begin
            next_sel.ram_cs = ram_cs;
        end else if (addon_cs != 4'h0) begin
            next_sel.addon_cs = addon_cs;
        end
    end

    // =============================================================
    // Registered selects, one cycle after the request
    always_comb begin
        next_site_cs = {next_sel.prog_cs, next_sel.ram_cs, next_sel.addon_cs};
        next_hit = |next_site_cs;
    end

    // One flop per site keeps each chip select free of decode glitches
    for (genvar i = 0; i < msd_pkg::NUM_SITES; i++) begin : g_site
        always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
                site_cs[i] <= 1'b0;
            end else begin
                site_cs[i] <= next_site_cs[i];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hit <= 1'b0;
        end else begin
            hit <= next_hit;
        end
    end

    // =============================================================
    // Output assembly
    always_comb begin
        sel.prog_cs = site_cs[11:8];
        sel.ram_cs = site_cs[7:4];
        sel.addon_cs = site_cs[3:0];
        sel.hit = hit;
    end

    // =============================================================
    // Protect status, a cycle behind any valid request made while protect is set, whatever its address
    always_comb begin
        next_ram_blocked = req.valid && mem_protect;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ram_blocked <= 1'b0;
        end else begin
            ram_blocked <= next_ram_blocked;
        end
    end

    // =============================================================
    // Bank base status
    // Re-latched every rising edge, so a strap change shows a cycle later
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            prog_base <= msd_pkg::BASE_RST;
        end else begin
            prog_base <= next_prog_base;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ram_base <= msd_pkg::BASE_RST;
        end else begin
            ram_base <= next_ram_base;
        end
    end
endmodule

// File: bench/msd_master.sv
// Local bus master model presenting one request per access
`timescale 1ns/1ps
module msd_master (
    input logic clk_sys,
    output msd_pkg::msd_req_t req
);
    initial req = '0;
    // Request on the next falling edge, released on the one after; a released address shows its inverse, not a stale copy
    task automatic access(input logic [19:0] a, input logic w);
        @(negedge clk_sys);
        req <= '{1'b1, w, a};
        @(negedge clk_sys);
        req <= '{1'b0, 1'b0, ~a};
    endtask
endmodule

// File: bench/msd_decoder_asserts.sv
// Assertion checker for the memory site decoder
`timescale 1ns/1ps
module msd_asserts (
    input logic clk_sys,
    input logic nrst,
    input msd_pkg::msd_req_t req,
    input msd_pkg::msd_density_t prog_density,
    input msd_pkg::msd_density_t ram_density,
    input logic ram_relocate,
    input logic addon_fitted,
    input logic mem_protect,
    input msd_pkg::msd_sel_t sel,
    input logic ram_blocked,
    input logic [19:0] prog_base,
    input logic [19:0] ram_base
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    AST_TOP: assert property (req.valid && req.addr == 20'hFFFFF |=> sel.prog_cs == 4'h8)
        else $error("top site");
    AST_BIG: assert property (
        prog_density == msd_pkg::MSD_DEN_64K |=> prog_base == 20'hC0000) else $error("big base");
    AST_SMALL: assert property (
        prog_density == msd_pkg::MSD_DEN_2K |=> prog_base == 20'hFE000) else $error("small base");
    AST_LOW: assert property (
        req.valid && req.addr == 20'h00000 && !ram_relocate && !mem_protect |=> sel.ram_cs == 4'h1)
        else $error("low site");
    AST_RELOC: assert property (
        ram_relocate && prog_density == msd_pkg::MSD_DEN_64K && ram_density == msd_pkg::MSD_DEN_8K
        |=> ram_base == 20'hB8000) else $error("relocated base");
    AST_ADD: assert property (
        req.valid && addon_fitted && !ram_relocate && !mem_protect && req.addr == 20'h08000
        && ram_density == msd_pkg::MSD_DEN_8K |=> sel.addon_cs == 4'h1) else $error("add-on site");
    AST_NOADD: assert property (!addon_fitted |=> sel.addon_cs == 4'h0)
        else $error("add-on absent");
    AST_PROT: assert property (req.valid && mem_protect |=> sel.ram_cs == 4'h0 && ram_blocked)
        else $error("protect");
    AST_IDLE: assert property (!req.valid |=> sel == '0) else $error("idle select");
endmodule
bind msd_decoder msd_asserts u_asserts (.*);

// File: bench/tb_top.sv
// Testbench for the memory site decoder
`timescale 1ns/1ps
module tb_top;
    logic clk_sys = 1'b0, nrst = 1'b0, ram_relocate = 1'b0, addon_fitted = 1'b0;
    logic mem_protect = 1'b0, ram_blocked;
    logic [19:0] prog_base, ram_base, b;
    msd_pkg::msd_density_t prog_density = msd_pkg::MSD_DEN_2K;
    msd_pkg::msd_density_t ram_density = msd_pkg::MSD_DEN_8K;
    msd_pkg::msd_density_t addon_density = msd_pkg::MSD_DEN_8K;
    msd_pkg::msd_req_t req;
    msd_pkg::msd_sel_t sel;
    int num_errors = 0, n_tests = 0;
    msd_master u_master (.clk_sys(clk_sys), .req(req));
    msd_decoder u_dut (.*);
    initial forever #12.5 clk_sys = ~clk_sys;
    task automatic cmp(input logic [19:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // Whole select word: hit must be set exactly when some site is selected
    task automatic acc(input logic [19:0] a, input logic [11:0] e, input logic w = 1'b0);
        u_master.access(a, w);
        cmp({7'h00, sel}, {7'h00, e, |e});
    endtask
    task automatic close_out;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial #50000 begin
        num_errors++;
        close_out;
    end
    initial begin
        repeat (3) @(negedge clk_sys);
        nrst = 1'b1;
        for (int d = 0; d < 5; d++) begin
            prog_density = msd_pkg::msd_density_t'(d);
            b = (d == 0) ? 20'hFE000 : 20'h00000 - (20'h04000 << d);
            acc(20'hFFFFF, 12'h800);
            acc(b, 12'h100);
            acc(b - 20'h00001, 12'h000);
            cmp(prog_base, b);
        end
        acc(20'h00000, 12'h010);
        cmp(ram_base, 20'h00000);
        acc(20'h07FFF, 12'h080);
        acc(20'h08000, 12'h000);
        addon_fitted = 1'b1;
        acc(20'h08000, 12'h001);
        acc(20'h0E000, 12'h008);
        ram_density = msd_pkg::MSD_DEN_2K;
        addon_density = msd_pkg::MSD_DEN_2K;
        acc(20'h01FFF, 12'h080);
        acc(20'h02000, 12'h001);
        acc(20'h03FFF, 12'h008);
        acc(20'h04000, 12'h000);
        mem_protect = 1'b1;
        acc(20'h00000, 12'h000, 1'b1);
        acc(20'h00000, 12'h000);
        acc(20'h02000, 12'h000);
        cmp({19'h00000, ram_blocked}, 20'h00001);
        mem_protect = 1'b0;
        ram_density = msd_pkg::MSD_DEN_8K;
        ram_relocate = 1'b1;
        acc(20'hBFFFF, 12'h080);
        cmp(ram_base, 20'hB8000);
        close_out;
    end
endmodule
